/* File: common/ocl_defines.svh */
`ifndef OCL_DEFINES_SVH
`define OCL_DEFINES_SVH
// Function
// - Select 01 high, 00 low, 10 converter two.
// - Apply high register only while select pin high.
// - Adjustable variant lacks high register; 11 unused.
// - One: high >= 2x low; zero: low >= 2x high.
// - Bit spans falling edge to next falling edge.
// - Acknowledge needs request bit, address match, 16 bits.
// - Acknowledge pulls line low for pulse time.
// - Pull-down starts after valid delay from last fall.
// - Host holds line low during valid delay.
// - Host releases after delay; low reads as acknowledge.
// - Mismatch or bad frame: no pull-down.
// - Host waits until acknowledge pulse ends.
// - Host requests acknowledge only when open-drain.
// - Line high forces PWM immediately.
// - Forced PWM holds through whole frame reception.
// - Low for full timeout enables power save.
// - Host sends frame first, then holds low.
// - Data byte: request bit7, select 6:5, setting 4:0.
// - Acknowledge open-drain active low, external pull-up.
// - Host precedes each byte with high start time.
// - Host ends each byte with end-of-stream low.
// - Power save only after mode timeout delay.
// - Interface active with an enable; ready after 170us.

// =============================================================
// Timing
`define OCL_CLK_MHZ 100
`define OCL_TIMEOUT_US 520
`define OCL_TIMEOUT_CYC (`OCL_TIMEOUT_US * `OCL_CLK_MHZ)
`define OCL_ACK_PULSE_US 520
`define OCL_ACK_PULSE_CYC (`OCL_ACK_PULSE_US * `OCL_CLK_MHZ)
`define OCL_ACK_VALID_US 2
`define OCL_ACK_VALID_CYC (`OCL_ACK_VALID_US * `OCL_CLK_MHZ)
`define OCL_STARTUP_US 170
`define OCL_STARTUP_CYC (`OCL_STARTUP_US * `OCL_CLK_MHZ)
`define OCL_CNT_W 17

// =============================================================
// Frame layout
`define OCL_DEV_ADDR 8'h5a
`define OCL_RFA_BIT 7
`define OCL_SEL_HI 6
`define OCL_SEL_LO 5
`define OCL_SEL_C1_LOW 2'h0
`define OCL_SEL_C1_HIGH 2'h1
`define OCL_SEL_C2 2'h2
`define OCL_C1_LOW_RST 5'h1f
`define OCL_C1_HIGH_RST 5'h08
`define OCL_C2_RST 5'h00

// =============================================================
// Host register map
`define OCL_REG_CMD 8'h00
`define OCL_REG_STATUS 8'h04
`define OCL_REG_CONFIG 8'h08
`define OCL_UNIT_RST 16'h00c8
`define OCL_ST_BUSY 0
`define OCL_ST_ACK 1
`define OCL_ST_NACK 2
`define OCL_CFG_PS 16
`endif

/* File: common/ocl_link_if.sv */
`timescale 1ns/100ps
interface ocl_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  // Pull-up wins unless a driver enables a low level.
  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport dev (input line, output dev_o, output dev_oe);
  modport host (input line, output host_o, output host_oe);
endinterface

/* File: common/ocl_pkg.sv */
`include "ocl_defines.svh"
package ocl_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_BIT, D_GAP, D_ACKDLY, D_ACK
  } ocl_dev_state_type;

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_LOW, H_HIGH, H_EOS, H_HOLD, H_SAMPLE, H_WAITEND
  } ocl_host_state_type;

  typedef struct packed {
    ocl_dev_state_type st;
    logic [`OCL_CNT_W-1:0] t_low;
    logic [`OCL_CNT_W-1:0] t_high;
    logic [`OCL_CNT_W-1:0] mode_cnt;
    logic [`OCL_CNT_W-1:0] tmr;
    logic [`OCL_CNT_W-1:0] rdy_cnt;
    logic ready;
    logic [3:0] nbits;
    logic [15:0] sr;
    logic bad;
    logic line_q;
    logic [4:0] c1_low;
    logic [4:0] c1_high;
    logic [4:0] c2;
    logic [4:0] c1_out;
    logic forced_pwm;
    logic ack_oe;
  } ocl_dev_reg_type;

  typedef struct packed {
    ocl_host_state_type st;
    logic [`OCL_CNT_W:0] cnt;
    logic [3:0] bitn;
    logic [15:0] sh;
    logic busy;
    logic ack_seen;
    logic nack;
    logic [15:0] unit;
    logic ps_hold;
    logic line_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ocl_host_reg_type;
endpackage

/* File: hw/ocl_device.sv */
`timescale 1ns/100ps
`include "ocl_defines.svh"
module ocl_device #(
  parameter int unsigned TIMEOUT_CYC = `OCL_TIMEOUT_CYC,
  parameter int unsigned ACK_PULSE_CYC = `OCL_ACK_PULSE_CYC,
  parameter int unsigned ACK_VALID_CYC = `OCL_ACK_VALID_CYC,
  parameter int unsigned STARTUP_CYC = `OCL_STARTUP_CYC,
  parameter bit ADJUSTABLE = 1'b0,
  parameter logic [7:0] DEV_ADDR = `OCL_DEV_ADDR
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link
  ocl_link_if.dev link,
  // Converter pins
  input wire logic conv1_select_pin_i,
  input wire logic conv1_enable_pin_i,
  input wire logic conv2_enable_pin_i,
  // Converter settings and mode
  output logic [4:0] conv1_setting_o,
  output logic [4:0] conv2_setting_o,
  output logic forced_pwm_o
);
  localparam int unsigned CMAX = (1 << `OCL_CNT_W) - 1;

  // =============================================================
  // Parameter checks
  initial begin
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > CMAX ||
        ACK_PULSE_CYC < 1 || ACK_PULSE_CYC > CMAX ||
        ACK_VALID_CYC < 1 || ACK_VALID_CYC > CMAX ||
        STARTUP_CYC < 1 || STARTUP_CYC > CMAX) begin
      $error("ocl_device: timing parameter out of range.");
    end
  end

  localparam logic [`OCL_CNT_W-1:0] TO = `OCL_CNT_W'(TIMEOUT_CYC);
  localparam logic [`OCL_CNT_W-1:0] AP = `OCL_CNT_W'(ACK_PULSE_CYC - 1);
  localparam logic [`OCL_CNT_W-1:0] AV = `OCL_CNT_W'(ACK_VALID_CYC - 1);
  localparam logic [`OCL_CNT_W-1:0] SU = `OCL_CNT_W'(STARTUP_CYC - 1);

  ocl_pkg::ocl_dev_reg_type s;
  ocl_pkg::ocl_dev_reg_type next_s;

  logic line;
  assign line = link.line;

  // =============================================================
  // Next state
  always_comb begin
    logic fall;
    logic one;
    logic zero;
    logic bad;
    logic [15:0] frame;
    logic [1:0] sel;
    next_s = s;
    fall = 1'b0;
    one = 1'b0;
    zero = 1'b0;
    bad = 1'b0;
    frame = 16'h0000;
    sel = 2'h0;
    next_s.line_q = line;
    fall = s.line_q & ~line;

    // Mode selection runs whether or not the interface is ready.
    if (line) begin
      next_s.forced_pwm = 1'b1;
      next_s.mode_cnt = '0;
    end else if (s.mode_cnt != TO) begin
      next_s.mode_cnt = s.mode_cnt + 1'b1;
    end else begin
      next_s.forced_pwm = 1'b0;
    end

    // Interface readiness after an enable rises.
    if (!(conv1_enable_pin_i || conv2_enable_pin_i)) begin
      next_s.ready = 1'b0;
      next_s.rdy_cnt = '0;
    end else if (!s.ready) begin
      if (s.rdy_cnt == SU) begin
        next_s.ready = 1'b1;
      end else begin
        next_s.rdy_cnt = s.rdy_cnt + 1'b1;
      end
    end

    // Bit classification of the interval that ends at this fall.
    one = ({1'b0, s.t_high} >= {s.t_low, 1'b0});
    zero = ({1'b0, s.t_low} >= {s.t_high, 1'b0});
    bad = s.bad | ~(one ^ zero);
    frame = {s.sr[14:0], one};
    sel = frame[`OCL_SEL_HI:`OCL_SEL_LO];

    unique case (s.st)
      ocl_pkg::D_IDLE: begin
        if (s.ready && fall) begin
          next_s.st = ocl_pkg::D_BIT;
          next_s.t_low = '0;
          next_s.t_high = '0;
          next_s.nbits = 4'h0;
          next_s.bad = 1'b0;
        end
      end
      ocl_pkg::D_BIT: begin
        if (fall) begin
          next_s.sr = frame;
          next_s.bad = bad;
          next_s.nbits = s.nbits + 4'h1;
          next_s.t_low = '0;
          next_s.t_high = '0;
          if (s.nbits == 4'h7) begin
            next_s.st = ocl_pkg::D_GAP;
          end else if (s.nbits == 4'hf) begin
            next_s.tmr = '0;
            next_s.st = ocl_pkg::D_IDLE;
            if (!bad && frame[15:8] == DEV_ADDR) begin
              unique case (sel)
                `OCL_SEL_C1_LOW: next_s.c1_low = frame[4:0];
                `OCL_SEL_C1_HIGH: begin
                  if (!ADJUSTABLE) begin
                    next_s.c1_high = frame[4:0];
                  end
                end
                `OCL_SEL_C2: next_s.c2 = frame[4:0];
                default: begin
                end
              endcase
              if (frame[`OCL_RFA_BIT]) begin
                next_s.st = ocl_pkg::D_ACKDLY;
              end
            end
          end
        end else if (s.t_low == TO || s.t_high == TO) begin
          // A timeout abandons the frame; a low that long has already ended
          // forced PWM one cycle before the frame is dropped.
          next_s.st = ocl_pkg::D_IDLE;
        end else if (line) begin
          next_s.t_high = s.t_high + 1'b1;
        end else begin
          next_s.t_low = s.t_low + 1'b1;
        end
      end
      ocl_pkg::D_GAP: begin
        // End-of-stream and start time between the bytes are skipped.
        if (fall) begin
          // The gap times must not leak into the first data bit.
          next_s.st = ocl_pkg::D_BIT;
          next_s.t_low = '0;
          next_s.t_high = '0;
        end else if (s.t_low == TO || s.t_high == TO) begin
          next_s.st = ocl_pkg::D_IDLE;
        end else if (line) begin
          next_s.t_high = s.t_high + 1'b1;
        end else begin
          next_s.t_low = s.t_low + 1'b1;
        end
      end
      ocl_pkg::D_ACKDLY: begin
        if (s.tmr == AV) begin
          next_s.st = ocl_pkg::D_ACK;
          next_s.ack_oe = 1'b1;
          next_s.tmr = '0;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
      ocl_pkg::D_ACK: begin
        if (s.tmr == AP) begin
          next_s.st = ocl_pkg::D_IDLE;
          next_s.ack_oe = 1'b0;
        end else begin
          next_s.tmr = s.tmr + 1'b1;
        end
      end
    endcase

    // Losing both enables stops the interface but keeps the settings.
    if (!next_s.ready) begin
      next_s.st = ocl_pkg::D_IDLE;
      next_s.ack_oe = 1'b0;
    end

    // Converter 1 follows the select pin unless ADJUSTABLE is set.
    if (conv1_select_pin_i && !ADJUSTABLE) begin
      next_s.c1_out = next_s.c1_high;
    end else begin
      next_s.c1_out = next_s.c1_low;
    end
  end

  // =============================================================
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= ocl_pkg::D_IDLE;
      s.line_q <= 1'b1;
      s.forced_pwm <= 1'b1;
      s.c1_low <= `OCL_C1_LOW_RST;
      s.c1_high <= `OCL_C1_HIGH_RST;
      s.c2 <= `OCL_C2_RST;
      s.c1_out <= `OCL_C1_LOW_RST;
    end else begin
      s <= next_s;
    end
  end

  // =============================================================
  // Outputs
  assign conv1_setting_o = s.c1_out;
  assign conv2_setting_o = s.c2;
  assign forced_pwm_o = s.forced_pwm;
  assign link.dev_o = 1'b0;
  assign link.dev_oe = s.ack_oe;
endmodule // ocl_device

/* File: hw/ocl_host.sv */
`timescale 1ns/100ps
`include "ocl_defines.svh"
module ocl_host #(
  parameter int unsigned ACK_VALID_CYC = `OCL_ACK_VALID_CYC,
  parameter logic [7:0] DEV_ADDR = `OCL_DEV_ADDR
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link
  ocl_link_if.host link
);
  initial begin
    if (ACK_VALID_CYC < 1 || ACK_VALID_CYC > 65535) begin
      $error("ocl_host: ACK_VALID_CYC out of range.");
    end
  end

  localparam int W = `OCL_CNT_W + 1;

  ocl_pkg::ocl_host_reg_type s;
  ocl_pkg::ocl_host_reg_type next_s;

  // =============================================================
  // Next state
  always_comb begin
    logic [W-1:0] u1;
    logic [W-1:0] u3;
    logic [W-1:0] u4;
    logic acc;
    logic bit_v;
    next_s = s;
    u1 = W'(s.unit);
    u3 = W'({s.unit, 1'b0}) + W'(s.unit);
    u4 = W'({s.unit, 2'b00});
    acc = psel_i & penable_i & s.pready;
    bit_v = s.sh[15];
    next_s.cnt = s.cnt + 1'b1;

    // APB: setup cycle registers the answer for the access phase.
    next_s.pready = psel_i & ~penable_i;
    if (psel_i && !penable_i) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr_i)
        `OCL_REG_CMD: next_s.pslverr = pwrite_i & s.busy;
        `OCL_REG_STATUS: begin
          next_s.pslverr = pwrite_i;
          next_s.prdata[`OCL_ST_BUSY] = s.busy;
          next_s.prdata[`OCL_ST_ACK] = s.ack_seen;
          next_s.prdata[`OCL_ST_NACK] = s.nack;
        end
        `OCL_REG_CONFIG: begin
          next_s.prdata[15:0] = s.unit;
          next_s.prdata[`OCL_CFG_PS] = s.ps_hold;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (acc && pwrite_i && !s.pslverr) begin
      if (paddr_i == `OCL_REG_CONFIG) begin
        next_s.unit = (pwdata_i[15:0] == 16'h0000) ? 16'h0001 :
                      pwdata_i[15:0];
        next_s.ps_hold = pwdata_i[`OCL_CFG_PS];
      end else if (paddr_i == `OCL_REG_CMD) begin
        next_s.sh = {DEV_ADDR, pwdata_i[7:0]};
        next_s.busy = 1'b1;
        next_s.ack_seen = 1'b0;
        next_s.nack = 1'b0;
        next_s.bitn = 4'h0;
        next_s.cnt = '0;
        next_s.st = ocl_pkg::H_START;
      end
    end

    unique case (s.st)
      ocl_pkg::H_IDLE: begin
        // Holding low after the frame selects power save.
        next_s.line_oe = s.ps_hold;
      end
      ocl_pkg::H_START: begin
        next_s.line_oe = 1'b0;
        if (s.cnt >= u4) begin
          next_s.st = ocl_pkg::H_LOW;
          next_s.line_oe = 1'b1;
          next_s.cnt = '0;
        end
      end
      ocl_pkg::H_LOW: begin
        if (s.cnt >= (bit_v ? u1 : u3)) begin
          next_s.st = ocl_pkg::H_HIGH;
          next_s.line_oe = 1'b0;
          next_s.cnt = '0;
        end
      end
      ocl_pkg::H_HIGH: begin
        if (s.cnt >= (bit_v ? u3 : u1)) begin
          next_s.line_oe = 1'b1;
          next_s.cnt = '0;
          next_s.sh = {s.sh[14:0], s.sh[15]};
          next_s.bitn = s.bitn + 4'h1;
          if (s.bitn == 4'h7) begin
            next_s.st = ocl_pkg::H_EOS;
          end else if (s.bitn == 4'hf) begin
            next_s.st = ocl_pkg::H_HOLD;
          end else begin
            next_s.st = ocl_pkg::H_LOW;
          end
        end
      end
      ocl_pkg::H_EOS: begin
        if (s.cnt >= u4) begin
          next_s.st = ocl_pkg::H_START;
          next_s.line_oe = 1'b0;
          next_s.cnt = '0;
        end
      end
      ocl_pkg::H_HOLD: begin
        // The shifter rotates, so after 16 bits the data byte is back
        // in place and bit 7 still holds the request flag.
        if (s.cnt >= W'(ACK_VALID_CYC) + u1) begin
          next_s.cnt = '0;
          if (s.sh[7]) begin
            next_s.st = ocl_pkg::H_SAMPLE;
            next_s.line_oe = 1'b0;
          end else begin
            next_s.st = ocl_pkg::H_IDLE;
            next_s.busy = 1'b0;
            next_s.line_oe = s.ps_hold;
          end
        end
      end
      ocl_pkg::H_SAMPLE: begin
        if (s.cnt >= u1) begin
          next_s.ack_seen = ~link.line;
          next_s.nack = link.line;
          next_s.st = ocl_pkg::H_WAITEND;
        end
      end
      ocl_pkg::H_WAITEND: begin
        if (link.line) begin
          next_s.st = ocl_pkg::H_IDLE;
          next_s.busy = 1'b0;
          next_s.line_oe = s.ps_hold;
        end
      end
    endcase
  end

  // =============================================================
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= ocl_pkg::H_IDLE;
      s.unit <= `OCL_UNIT_RST;
    end else begin
      s <= next_s;
    end
  end

  // =============================================================
  // Outputs
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  // Open-drain only, so requesting an acknowledge is always safe.
  assign link.host_o = 1'b0;
  assign link.host_oe = s.line_oe;
endmodule // ocl_host

/* File: sim/ocl_link_properties.sv */
`timescale 1ns/100ps
module ocl_link_properties #(
  parameter int ACK_PULSE_CYC = 300,
  parameter int ACK_VALID_CYC = 20,
  parameter int TIMEOUT_CYC = 400
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link wires
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line,
  // Device mode
  input wire logic forced_pwm_o
);
  // ==========================================================
  // Counters
  int low_cnt;
  int ack_cnt;

  // Saturation keeps a long power-save hold from wrapping.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || line) low_cnt <= 0;
    else if (low_cnt < 100000) low_cnt <= low_cnt + 1;
    if (!rst_n_i || !dev_oe) ack_cnt <= 0;
    else ack_cnt <= ack_cnt + 1;
  end

  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ack_on; $rose(dev_oe); endsequence
  sequence s_ack_off; $fell(dev_oe); endsequence
  sequence s_frame_fall; $fell(line) && forced_pwm_o; endsequence

  AST_ACK_WIDTH: assert property (s_ack_off |-> ack_cnt == ACK_PULSE_CYC)
    else $error("ack pulse length wrong");
  AST_ACK_MAX: assert property (ack_cnt <= ACK_PULSE_CYC)
    else $error("ack pulse too long");
  AST_ACK_DELAY: assert property (s_ack_on |->
    low_cnt inside {[ACK_VALID_CYC:ACK_VALID_CYC+2]})
    else $error("ack started at wrong time");
  AST_HOST_RELEASE: assert property (s_ack_on |-> ##[1:40] !host_oe)
    else $error("host kept line low during ack");
  AST_HOST_WAIT: assert property (dev_oe && !host_oe |=> !host_oe)
    else $error("host drove line during ack");
  AST_HOST_HOLD: assert property (s_ack_on |-> host_oe)
    else $error("host released line before ack");
  AST_PULLUP: assert property (s_ack_off ##0 !host_oe |-> line)
    else $error("line not high after ack");
  AST_PWM_ON_HIGH: assert property (line |=> forced_pwm_o)
    else $error("forced pwm not set on high line");
  AST_PWM_FRAME: assert property (s_frame_fall |-> forced_pwm_o[*8])
    else $error("forced pwm dropped in frame");
  AST_PS_DELAY: assert property ($fell(forced_pwm_o) |->
    low_cnt >= TIMEOUT_CYC)
    else $error("power save too early");
  AST_PS_ENTER: assert property (low_cnt == TIMEOUT_CYC + 3 |->
    !forced_pwm_o)
    else $error("power save not entered");
  AST_OPEN_DRAIN: assert property (!host_o && !dev_o)
    else $error("driver level not low");
endmodule // ocl_link_properties

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`include "ocl_defines.svh"
module testbench;
  localparam int TO = 400;
  localparam int AP = 300;
  localparam int AV = 20;
  localparam int SU = 50;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fpwm, line_q, ack_b;
  logic mon_bad = 1'b0;
  logic sel_pin = 1'b0, en1 = 1'b0, en2 = 1'b0, lb_oe = 1'b0;
  logic [4:0] c1_set, c2_set, c1_b, c2_b;
  logic [15:0] mon_word;
  logic [31:0] seed = 32'h0001_25c8;
  int bad_count = 0;
  int num_checks = 0;
  int m_low = 5'h1f, m_high = 5'h08, m_c2 = 5'h00;
  int lo_n = 0, hi_n = 0;

  ocl_link_if link_a();
  ocl_link_if link_b();
  assign link_b.host_o = 1'b0;
  assign link_b.host_oe = lb_oe;
  always #5 ref_clk_i = ~ref_clk_i;

  ocl_host #(.ACK_VALID_CYC(AV)) i_ocl_host (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .link(link_a.host));
  ocl_device #(.TIMEOUT_CYC(TO), .ACK_PULSE_CYC(AP), .ACK_VALID_CYC(AV),
    .STARTUP_CYC(SU)) i_ocl_device (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .link(link_a.dev), .conv1_select_pin_i(sel_pin),
    .conv1_enable_pin_i(en1), .conv2_enable_pin_i(en2),
    .conv1_setting_o(c1_set), .conv2_setting_o(c2_set),
    .forced_pwm_o(fpwm));
  // The second device faces a hand driver that can break the bit rules.
  ocl_device #(.TIMEOUT_CYC(TO), .ACK_PULSE_CYC(AP), .ACK_VALID_CYC(AV),
    .STARTUP_CYC(SU)) i_ocl_device_b (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .link(link_b.dev), .conv1_select_pin_i(1'b0),
    .conv1_enable_pin_i(1'b1), .conv2_enable_pin_i(1'b0),
    .conv1_setting_o(c1_b), .conv2_setting_o(c2_b), .forced_pwm_o());
  ocl_link_properties #(.ACK_PULSE_CYC(AP), .ACK_VALID_CYC(AV),
    .TIMEOUT_CYC(TO)) i_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .host_o(link_a.host_o), .host_oe(link_a.host_oe),
    .dev_o(link_a.dev_o), .dev_oe(link_a.dev_oe), .line(link_a.line),
    .forced_pwm_o(fpwm));

  // ==========================================================
  // Wire monitor
  // Periods longer than a bit are gaps, start or idle and are skipped.
  always @(posedge ref_clk_i) begin
    line_q <= link_a.line;
    if (line_q && !link_a.line) begin
      if (lo_n + hi_n < 60) begin
        mon_word <= {mon_word[14:0], hi_n > lo_n};
        if (hi_n < 2 * lo_n && lo_n < 2 * hi_n) mon_bad <= 1'b1;
      end
      lo_n <= 1;
      hi_n <= 0;
    end else if (link_a.line) hi_n <= hi_n + 1;
    else lo_n <= lo_n + 1;
  end

  // ==========================================================
  // Tasks
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic frame(input logic [7:0] cmd, input logic rdy);
    logic [31:0] r;
    logic e;
    apb(1'b1, `OCL_REG_CMD, {24'h0, cmd}, r, e);
    apb(1'b1, `OCL_REG_CMD, {24'h0, cmd}, r, e);
    chk(e, 1'b1, "command while busy");
    r = 32'h1;
    while (r[`OCL_ST_BUSY] !== 1'b0) begin
      apb(1'b0, `OCL_REG_STATUS, 32'h0, r, e);
    end
    if (rdy && cmd[6:5] == 2'h0) m_low = cmd[4:0];
    if (rdy && cmd[6:5] == 2'h1) m_high = cmd[4:0];
    if (rdy && cmd[6:5] == 2'h2) m_c2 = cmd[4:0];
    if (cmd[7]) chk(r[2:1], {~rdy, rdy}, "ack status");
    else chk(r[2:1], 2'b00, "no ack request");
    chk(mon_word, {`OCL_DEV_ADDR, cmd}, "wire word");
    chk(c1_set, sel_pin ? m_high : m_low, "conv1 setting");
    chk(c2_set, m_c2, "conv2 setting");
  endtask

  task automatic bb_bit(input int lo, input int hi);
    lb_oe <= 1'b1;
    repeat (lo) @(posedge ref_clk_i);
    lb_oe <= 1'b0;
    repeat (hi) @(posedge ref_clk_i);
  endtask

  task automatic bb_frame(input logic [15:0] w, input int bad_idx);
    int i;
    repeat (40) @(posedge ref_clk_i);
    for (i = 15; i >= 0; i--) begin
      if (i == 7) bb_bit(40, 40);
      if (i == bad_idx) bb_bit(20, 20);
      else if (w[i]) bb_bit(10, 30);
      else bb_bit(30, 10);
    end
    bb_bit(60, 10);
    ack_b = ~link_b.line;
    repeat (600) @(posedge ref_clk_i);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    bad_count++;
    $display("ERROR %0t timeout", $time);
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic e;
    int k;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({fpwm, c1_set, c2_set}, {1'b1, 5'h1f, 5'h00}, "reset values");
    apb(1'b1, `OCL_REG_CONFIG, 32'h0000_000a, r, e);
    apb(1'b0, `OCL_REG_CONFIG, 32'h0, r, e);
    chk({e, r}, {1'b0, 32'h0000_000a}, "config readback");
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, `OCL_REG_STATUS, 32'h0, r, e);
    chk(e, 1'b1, "status write");
    frame(8'hc3, 1'b0);
    en2 <= 1'b1;
    repeat (SU + 5) @(posedge ref_clk_i);
    en1 <= 1'b1;
    for (k = 0; k < 8; k++) begin
      r = xs();
      sel_pin <= r[8];
      @(posedge ref_clk_i);
      frame({r[7] & (k[1:0] != 2'h3), k[1:0], r[4:0]}, 1'b1);
      sel_pin <= ~sel_pin;
      repeat (3) @(posedge ref_clk_i);
      chk(c1_set, sel_pin ? m_high : m_low, "select pin");
    end
    apb(1'b1, `OCL_REG_CONFIG, 32'h0001_000a, r, e);
    repeat (TO + 20) @(posedge ref_clk_i);
    chk(fpwm, 1'b0, "power save");
    apb(1'b1, `OCL_REG_CONFIG, 32'h0000_000a, r, e);
    repeat (3) @(posedge ref_clk_i);
    chk(fpwm, 1'b1, "forced pwm");
    chk(mon_bad, 1'b0, "bit ratio");
    bb_frame({8'ha5, 8'hd5}, -1);
    chk({ack_b, c2_b}, 6'h00, "bad address");
    bb_frame({`OCL_DEV_ADDR, 8'hd5}, 3);
    chk({ack_b, c2_b}, 6'h00, "bad bit");
    bb_frame({`OCL_DEV_ADDR, 8'hd5}, -1);
    chk({ack_b, c2_b}, 6'h35, "good frame");
    conclude();
  end
endmodule // testbench
